// ---- verilog/eac_pkg.sv ----
// constants and types shared by the eeprom access control block
`default_nettype none
package eac_pkg;
    // io-space offsets
    localparam logic [5:0] CONTROL_OFFSET = 6'h1C;
    localparam logic [5:0] DATA_OFFSET = 6'h1D;
    localparam logic [5:0] ADDRESS_OFFSET = 6'h1E;
    // control register field positions
    localparam int READ_STROBE_BIT = 0;
    localparam int PROG_ENABLE_BIT = 1;
    localparam int MASTER_PROG_ENABLE_BIT = 2;
    localparam int READY_IRQ_ENABLE_BIT = 3;
    localparam int PROG_MODE_LO_BIT = 4;
    localparam int PROG_MODE_HI_BIT = 5;
    // reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] PROG_MODE_RESET = 2'h0;
    // mode encodings
    localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
    localparam logic [1:0] MODE_ERASE_ONLY = 2'h1;
    localparam logic [1:0] MODE_WRITE_ONLY = 2'h2;
    // timing and array depth
    localparam real ERASE_WRITE_TIME_MS = 3.4;
    localparam real SINGLE_OP_TIME_MS = 1.8;
    localparam real OSC_FREQ_MHZ = 8.0;
    localparam int MASTER_WINDOW_CYCLES = 4;
    localparam int PROG_STALL_CYCLES = 2;
    localparam int READ_STALL_CYCLES = 4;
    localparam int ARRAY_DEPTH = 256;
    // one io access from the core
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [5:0] addr;
        logic [7:0] wrData;
    } eac_io_req_t;
endpackage
`default_nettype wire

// ---- verilog/eac_down_counter.sv ----
// loadable down counter with expiry pulse
`timescale 1ns/1ps
`default_nettype none
module eac_down_counter #(
    parameter int WIDTH = 16
) (
    input wire logic core_clk,            // system clock
    input wire logic rst,                 // sync reset
    input wire logic load,                // load start value
    input wire logic [WIDTH-1:0] loadVal, // start value
    input wire logic tick,                // count enable
    output logic busy,                    // counting
    output logic expired                  // one-cycle end pulse
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            count <= '0;
            busy <= 1'b0;
            expired <= 1'b0;
        end
        else
        begin
            expired <= 1'b0;
            if (load)
            begin
                count <= loadVal;
                busy <= 1'b1;
            end
            else if (busy && tick)
            begin
                if (count <= WIDTH'(1))
                begin
                    busy <= 1'b0;
                    expired <= 1'b1;
                    count <= '0;
                end
                else
                    count <= count - WIDTH'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ---- verilog/eac_eeprom_access_control.sv ----
// eeprom access control: registers, programming sequencer, array storage
`timescale 1ns/1ps
`default_nettype none
module eac_eeprom_access_control #(
    parameter int OSC_DIV = 1,                       // oscTickIn pulses per timebase tick
    parameter int ERASE_WRITE_TICKS = $rtoi(eac_pkg::ERASE_WRITE_TIME_MS * eac_pkg::OSC_FREQ_MHZ * 1000.0),
    parameter int SINGLE_OP_TICKS = $rtoi(eac_pkg::SINGLE_OP_TIME_MS * eac_pkg::OSC_FREQ_MHZ * 1000.0)
) (
    input wire logic core_clk,                  // 40 MHz system clock
    input wire logic rst,                       // sync reset, active high
    input wire eac_pkg::eac_io_req_t ioReq,     // io access from core
    input wire logic globalIrqEnable,           // i-bit of cpu_status_reg
    input wire logic oscTickIn,                 // calibrated oscillator tick, core domain
    output logic [7:0] ioRdData,                // read data, registered
    output logic cpuStall,                      // halt core
    output logic readyIrq                       // ready interrupt level
);
    localparam int CW = 16;
    logic [7:0] eeprom_data_reg;
    logic [7:0] eeprom_address_reg;
    logic [1:0] prog_mode_field;
    logic ready_irq_enable;
    logic master_prog_enable;
    logic prog_enable;
    logic [2:0] masterCount;
    logic [2:0] stallCount;
    logic [7:0] storage [eac_pkg::ARRAY_DEPTH];
    logic [7:0] progAddr;
    logic [7:0] progData;
    logic [1:0] progMode;
    logic [15:0] divCount;
    logic oscTick;
    logic startProg;
    logic doRead;
    logic ctrlWrite;
    logic [CW-1:0] loadTicks;
    logic progBusy;
    logic progDone;
    logic [7:0] ctrlRead;

    assign ctrlWrite = ioReq.wrEn && ioReq.addr == eac_pkg::CONTROL_OFFSET;
    assign startProg = ctrlWrite && ioReq.wrData[eac_pkg::PROG_ENABLE_BIT] && master_prog_enable
        && !prog_enable;
    assign doRead = ctrlWrite && ioReq.wrData[eac_pkg::READ_STROBE_BIT] && !prog_enable;
    assign loadTicks = (prog_mode_field == eac_pkg::MODE_ERASE_WRITE) ? CW'(ERASE_WRITE_TICKS)
        : CW'(SINGLE_OP_TICKS);

    // oscillator tick divider
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            divCount <= '0;
            oscTick <= 1'b0;
        end
        else
        begin
            oscTick <= 1'b0;
            if (oscTickIn)
            begin
                if (divCount >= 16'(OSC_DIV - 1))
                begin
                    divCount <= '0;
                    oscTick <= 1'b1;
                end
                else
                    divCount <= divCount + 16'h0001;
            end
        end
    end

    eac_down_counter #(
        .WIDTH(CW)
    ) u_duration (
        .core_clk(core_clk),
        .rst(rst),
        .load(startProg),
        .loadVal(loadTicks),
        .tick(oscTick),
        .busy(progBusy),
        .expired(progDone)
    );

    // program enable and mode field
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            // reset clears the duration counter too, so a running operation ends here
            prog_enable <= 1'b0;
            if (!prog_enable)
                prog_mode_field <= eac_pkg::PROG_MODE_RESET;
        end
        else
        begin
            if (startProg)
                prog_enable <= 1'b1;
            else if (progDone)
                prog_enable <= 1'b0;
            if (ctrlWrite && !prog_enable)
                prog_mode_field <= ioReq.wrData[eac_pkg::PROG_MODE_HI_BIT:eac_pkg::PROG_MODE_LO_BIT];
        end
    end

    // master enable window
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            master_prog_enable <= 1'b0;
            masterCount <= '0;
            ready_irq_enable <= 1'b0;
        end
        else
        begin
            if (ctrlWrite)
                ready_irq_enable <= ioReq.wrData[eac_pkg::READY_IRQ_ENABLE_BIT];
            if (ctrlWrite && ioReq.wrData[eac_pkg::MASTER_PROG_ENABLE_BIT])
            begin
                master_prog_enable <= 1'b1;
                masterCount <= 3'(eac_pkg::MASTER_WINDOW_CYCLES);
            end
            else if (masterCount != 3'h0)
            begin
                masterCount <= masterCount - 3'h1;
                if (masterCount == 3'h1)
                    master_prog_enable <= 1'b0;
            end
        end
    end

    // address and data registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
            eeprom_data_reg <= eac_pkg::DATA_RESET;
        else if (doRead)
            eeprom_data_reg <= storage[eeprom_address_reg];
        else if (ioReq.wrEn && ioReq.addr == eac_pkg::DATA_OFFSET)
            eeprom_data_reg <= ioReq.wrData;
    end

    always_ff @(posedge core_clk)
    begin
        if (ioReq.wrEn && ioReq.addr == eac_pkg::ADDRESS_OFFSET && !prog_enable)
            eeprom_address_reg <= ioReq.wrData;
    end

    // latch operation at start, apply to array at end
    always_ff @(posedge core_clk)
    begin
        if (startProg)
        begin
            progAddr <= eeprom_address_reg;
            progData <= eeprom_data_reg;
            progMode <= prog_mode_field;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (progDone)
        begin
            case (progMode)
                eac_pkg::MODE_ERASE_WRITE: storage[progAddr] <= progData;
                eac_pkg::MODE_ERASE_ONLY: storage[progAddr] <= 8'hFF;
                eac_pkg::MODE_WRITE_ONLY: storage[progAddr] <= storage[progAddr] & progData;
                default: storage[progAddr] <= storage[progAddr];
            endcase
        end
    end

    // core stall
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stallCount <= '0;
            cpuStall <= 1'b0;
        end
        else if (doRead)
        begin
            stallCount <= 3'(eac_pkg::READ_STALL_CYCLES - 1);
            cpuStall <= 1'b1;
        end
        else if (startProg)
        begin
            stallCount <= 3'(eac_pkg::PROG_STALL_CYCLES - 1);
            cpuStall <= 1'b1;
        end
        else if (stallCount != 3'h0)
            stallCount <= stallCount - 3'h1;
        else
            cpuStall <= 1'b0;
    end

    assign ctrlRead = {2'b00, prog_mode_field, ready_irq_enable, master_prog_enable, prog_enable,
        1'b0};

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ioRdData <= 8'h00;
            readyIrq <= 1'b0;
        end
        else
        begin
            readyIrq <= ready_irq_enable && globalIrqEnable && !prog_enable;
            case (ioReq.addr)
                eac_pkg::CONTROL_OFFSET: ioRdData <= ctrlRead;
                eac_pkg::DATA_OFFSET: ioRdData <= eeprom_data_reg;
                eac_pkg::ADDRESS_OFFSET: ioRdData <= eeprom_address_reg;
                default: ioRdData <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- test/eac_osc_model.sv ----
// oscillator tick model feeding the programming timebase
`timescale 1ns/1ps
`default_nettype none
module eac_osc_model #(
    parameter int DIV = 2
) (
    input wire logic core_clk, // system clock
    input wire logic rst,      // sync reset
    output logic oscTick       // one-cycle tick
);
    int cnt;
    always_ff @(posedge core_clk)
    begin
        cnt <= (rst || cnt == DIV - 1) ? 0 : cnt + 1;
        oscTick <= !rst && cnt == DIV - 1;
    end
endmodule
`default_nettype wire

// ---- test/eac_eeprom_access_control_props.sv ----
// port assertions for the eeprom access control block
`timescale 1ns/1ps
`default_nettype none
module eac_eeprom_access_control_props (
    input wire logic core_clk,             // clock
    input wire logic rst,                  // sync reset
    input wire eac_pkg::eac_io_req_t ioReq, // io access
    input wire logic globalIrqEnable,      // global enable
    input wire logic oscTickIn,            // osc tick
    input wire logic [7:0] ioRdData,       // read data
    input wire logic cpuStall,             // core halt
    input wire logic readyIrq              // ready level
);
    logic [2:0] armAge;
    logic ctlWr;
    assign ctlWr = ioReq.wrEn && ioReq.addr == eac_pkg::CONTROL_OFFSET;
    // cycles since arming, saturating at 7
    always_ff @(posedge core_clk)
    begin
        if (rst)
            armAge <= 3'h7;
        else if (ctlWr && ioReq.wrData[2])
            armAge <= 3'h1;
        else if (armAge != 3'h7)
            armAge <= armAge + 3'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property ($fell(rst) |-> ioRdData == 8'h00 && !cpuStall && !readyIrq)
        else $error("outputs not quiet after reset");
    a_ctrl_reserved_zero: assert property (ioReq.addr == eac_pkg::CONTROL_OFFSET |=> ioRdData[7:6] == 2'h0)
        else $error("control reserved bits not zero");
    a_stall_width: assert property ($rose(cpuStall) |-> (cpuStall[*2] ##1 !cpuStall) or (cpuStall[*4] ##1 !cpuStall))
        else $error("stall length wrong");
    a_stall_cause: assert property ($rose(cpuStall) |-> $past(ctlWr && ioReq.wrData[1:0] != 2'h0))
        else $error("stall without start or strobe");
    a_irq_gated: assert property (!globalIrqEnable |=> !readyIrq)
        else $error("ready irq without global enable");
    a_irq_busy_low: assert property ($rose(cpuStall) ##1 cpuStall ##1 !cpuStall |-> !readyIrq)
        else $error("ready irq while programming");
    a_data_readback: assert property (ioReq.wrEn && ioReq.addr == eac_pkg::DATA_OFFSET
        ##1 !ioReq.wrEn && ioReq.addr == eac_pkg::DATA_OFFSET |=> ioRdData == $past(ioReq.wrData, 2))
        else $error("data register readback wrong");
    a_master_needed: assert property (ctlWr && ioReq.wrData[2:1] == 2'h1 && armAge == 3'h7 |=> !$rose(cpuStall))
        else $error("program start without arming");
endmodule
bind eac_eeprom_access_control eac_eeprom_access_control_props props_u (.core_clk(core_clk), .rst(rst),
    .ioReq(ioReq), .globalIrqEnable(globalIrqEnable), .oscTickIn(oscTickIn), .ioRdData(ioRdData),
    .cpuStall(cpuStall), .readyIrq(readyIrq));
`default_nettype wire

// ---- test/test_eac_eeprom_access_control.sv ----
// self-checking bench for the eeprom access control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin errors++; $display("mismatch t=%0t got %h want %h", $time, a, e); end end
module test_eac_eeprom_access_control;
    localparam int EW = 20;
    localparam int SO = 10;
    localparam logic [5:0] CTL = eac_pkg::CONTROL_OFFSET;
    localparam logic [5:0] DAT = eac_pkg::DATA_OFFSET;
    localparam logic [5:0] ADR = eac_pkg::ADDRESS_OFFSET;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic globalIrqEnable = 1'b0;
    logic oscTick;
    eac_pkg::eac_io_req_t ioReq = '0;
    logic [7:0] ioRdData;
    logic cpuStall;
    logic readyIrq;
    int errors = 0;
    int numChecks = 0;
    always #12.5 core_clk = ~core_clk;
    eac_osc_model osc_u (.core_clk(core_clk), .rst(rst), .oscTick(oscTick));
    eac_eeprom_access_control #(.ERASE_WRITE_TICKS(EW), .SINGLE_OP_TICKS(SO)) dut_u (.core_clk(core_clk),
        .rst(rst), .ioReq(ioReq), .globalIrqEnable(globalIrqEnable), .oscTickIn(oscTick),
        .ioRdData(ioRdData), .cpuStall(cpuStall), .readyIrq(readyIrq));
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        ioReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        @(posedge core_clk);
        ioReq.wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge core_clk);
        ioReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
        @(posedge core_clk);
        ioReq.rdEn <= 1'b0;
        #1 `CHK(ioRdData, e)
    endtask
    // program one byte, poke refused fields while busy, then fetch it back
    task automatic prog(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        int n;
        int t;
        t = (m == 2'h0) ? EW : SO;
        wr(ADR, a);
        wr(DAT, d);
        wr(CTL, {2'h0, m, 4'hC});
        wr(CTL, {2'h0, m, 4'hA});
        #1 `CHK(cpuStall, 1'b1)
        wr(CTL, {2'h0, ~m, 4'hB});
        #1 `CHK(cpuStall, 1'b0)
        `CHK(readyIrq, 1'b0)
        wr(ADR, ~a);
        n = 4;
        while (readyIrq !== 1'b1 && n < 400)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(n > 2 * t - 5 && n < 2 * t + 6, 1'b1)
        rd(CTL, {2'h0, m, 4'h8});
        rd(ADR, a);
        rd(DAT, d);
        wr(CTL, {2'h0, m, 4'h9});
        rd(DAT, e);
        `CHK(cpuStall, 1'b1)
    endtask
    task automatic tallyAndFinish();
        $display("errors %0d checks %0d", errors, numChecks);
        if (errors == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(CTL, 8'h00);
        rd(DAT, eac_pkg::DATA_RESET);
        rd(6'h3F, 8'h00);
        wr(DAT, 8'hA5);
        rd(DAT, 8'hA5);
        wr(CTL, 8'h04);
        repeat (8) @(posedge core_clk);
        rd(CTL, 8'h00);
        wr(CTL, 8'h02);
        rd(CTL, 8'h00);
        globalIrqEnable <= 1'b1;
        prog(2'h0, 8'h10, 8'h3C, 8'h3C);
        prog(2'h1, 8'h10, 8'h00, 8'hFF);
        prog(2'h2, 8'h10, 8'h5A, 8'h5A);
        prog(2'h2, 8'h10, 8'h0F, 8'h0A);
        prog(2'h3, 8'h10, 8'hC3, 8'h0A);
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        rd(CTL, 8'h00);
        // reset while busy keeps the mode field
        wr(CTL, 8'h14);
        wr(CTL, 8'h12);
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        rd(CTL, 8'h10);
        tallyAndFinish();
    end
    // hang guard, well beyond the expected run
    initial
    begin
        #200000;
        errors++;
        tallyAndFinish();
    end
endmodule
`default_nettype wire
